// [hdl/rsi_pkg.sv]
package rsi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SETMASK = 8'h00;
  localparam logic [7:0] OFS_READMASK = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_DISABLE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Set-interrupt-mask write fields
  localparam int SM_SOD_BIT = 7;
  localparam int SM_SOE_BIT = 6;
  localparam int SM_R75_BIT = 4;
  localparam int SM_MSE_BIT = 3;
  // Read-interrupt-mask read fields
  localparam int RM_SID_BIT = 7;
  localparam int RM_P75_BIT = 6;
  localparam int RM_P65_BIT = 5;
  localparam int RM_P55_BIT = 4;
  localparam int RM_IE_BIT = 3;
  // Mask vector bit positions
  localparam int MB_55 = 0;
  localparam int MB_65 = 1;
  localparam int MB_75 = 2;
  // Restart vectors
  localparam logic [7:0] VEC_TRAP = 8'h24;
  localparam logic [7:0] VEC_75 = 8'h3C;
  localparam logic [7:0] VEC_65 = 8'h34;
  localparam logic [7:0] VEC_55 = 8'h2C;
  localparam logic [7:0] VEC_BUS = 8'h00;
  // Reset values
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic SOD_RST = 1'b0;
  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rsi_pkg

// [hdl/rsi_sync.sv]
`timescale 1ns/1ps
module rsi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } rsi_sync_s;

  rsi_sync_s sy_q;
  rsi_sync_s sy_d;

  // Output follows only once stages two and three agree
  always_comb begin
    sy_d = sy_q;
    sy_d.s1 = async_i;
    sy_d.s2 = sy_q.s1;
    sy_d.s3 = sy_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (sy_q.s2[i] == sy_q.s3[i]) begin
        sy_d.lvl[i] = sy_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign level_o = sy_q.lvl;
endmodule : rsi_sync

// [hdl/rsi_ctrl.sv]
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module rsi_ctrl
  import rsi_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SAMPLE_POINT_I,
  input wire logic NONMASKABLE_I,
  input wire logic RESTART75_I,
  input wire logic RESTART65_I,
  input wire logic RESTART55_I,
  input wire logic BUS_VECTORED_REQUEST_I,
  input wire logic SERIAL_IN_LINE_I,
  input wire logic HOLD_REQUEST_I,
  output logic HOLD_REQUEST_SYNC_O,
  output logic SERIAL_OUT_LINE_O,
  output logic INT_TAKEN_O,
  output logic [7:0] VECTOR_O,
  output logic VECTOR_FETCH_ACK_O
);
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] masks;
    logic ie;
    logic ie_saved;
    logic trap_rim;
    logic r75_ff;
    logic trap_edge;
    logic trap_prev;
    logic r75_prev;
    logic serial_out_line;
    logic taken;
    logic ack;
    logic [7:0] vector;
  } rsi_state_s;

  rsi_state_s s_q;
  rsi_state_s s_d;
  logic [6:0] sync_lvl;
  logic trap_lvl, r75_lvl, r65_lvl, r55_lvl, bus_lvl, sid_lvl;
  logic r75_edge, trap_rise;
  logic trap_req, req75, req65, req55, req_bus;
  logic accept;
  logic sim_wr, rim_rd;
  logic [7:0] rim_val;
  logic [7:0] wofs;
  logic [7:0] rofs;

  rsi_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .async_i({HOLD_REQUEST_I, SERIAL_IN_LINE_I, BUS_VECTORED_REQUEST_I, RESTART55_I, RESTART65_I, RESTART75_I,
              NONMASKABLE_I}),
    .level_o(sync_lvl)
  );

  assign trap_lvl = sync_lvl[0];
  assign r75_lvl = sync_lvl[1];
  assign r65_lvl = sync_lvl[2];
  assign r55_lvl = sync_lvl[3];
  assign bus_lvl = sync_lvl[4];
  assign sid_lvl = sync_lvl[5];
  assign HOLD_REQUEST_SYNC_O = sync_lvl[6];

  assign r75_edge = r75_lvl && !s_q.r75_prev;
  assign trap_rise = trap_lvl && !s_q.trap_prev;
  // Edge and level both needed; a dropped line cancels the request
  assign trap_req = s_q.trap_edge && trap_lvl;
  assign req75 = s_q.r75_ff && !s_q.masks[MB_75] && s_q.ie;
  assign req65 = r65_lvl && !s_q.masks[MB_65] && s_q.ie;
  assign req55 = r55_lvl && !s_q.masks[MB_55] && s_q.ie;
  assign req_bus = bus_lvl && s_q.ie;
  assign accept = SAMPLE_POINT_I && (trap_req || req75 || req65 || req55 || req_bus);

  assign wofs = 8'(s_q.aw_addr);
  assign rofs = 8'(S_AXI_ARADDR_I);
  assign sim_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.wstrb0 && wofs == OFS_SETMASK;
  assign rim_rd = S_AXI_ARVALID_I && s_q.arready && rofs == OFS_READMASK;
  // Saved enable shown once after a trap
  assign rim_val = {sid_lvl, s_q.r75_ff, r65_lvl, r55_lvl,
                    s_q.trap_rim ? s_q.ie_saved : s_q.ie, s_q.masks};

  always_comb begin
    s_d = s_q;
    s_d.taken = 1'b0;
    s_d.ack = 1'b0;
    s_d.trap_prev = trap_lvl;
    s_d.r75_prev = r75_lvl;

    // Write channel: address and data in either order
    if (S_AXI_AWVALID_I && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = S_AXI_WDATA_I[7:0];
      s_d.wstrb0 = S_AXI_WSTRB_I[0];
    end
    if (s_q.bvalid && S_AXI_BREADY_I) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (wofs)
        OFS_SETMASK: begin
          if (s_q.wstrb0) begin
            if (s_q.wdata[SM_MSE_BIT]) begin
              s_d.masks = s_q.wdata[2:0];
            end
            if (s_q.wdata[SM_R75_BIT]) begin
              s_d.r75_ff = 1'b0;
            end
            if (s_q.wdata[SM_SOE_BIT]) begin
              s_d.serial_out_line = s_q.wdata[SM_SOD_BIT];
            end
          end
        end
        OFS_ENABLE: begin
          if (s_q.wstrb0) begin
            s_d.ie = 1'b1;
          end
        end
        OFS_DISABLE: begin
          if (s_q.wstrb0) begin
            s_d.ie = 1'b0;
          end
        end
        OFS_READMASK, OFS_STATUS: begin
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s_q.rvalid && S_AXI_RREADY_I) begin
      s_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      unique case (rofs)
        OFS_READMASK: begin
          s_d.rdata = {24'h000000, rim_val};
          s_d.trap_rim = 1'b0;
        end
        OFS_STATUS: begin
          s_d.rdata = {16'h0000, s_q.vector, 4'h0, s_q.trap_rim, s_q.ie_saved, s_q.trap_edge, s_q.ie};
        end
        OFS_SETMASK, OFS_ENABLE, OFS_DISABLE: begin
        end
        default: begin
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Acceptance; no memory of a running handler is kept
    if (accept) begin
      s_d.taken = 1'b1;
      s_d.ie = 1'b0;
      s_d.trap_rim = 1'b0;
      if (trap_req) begin
        s_d.vector = VEC_TRAP;
        s_d.ie_saved = s_q.ie;
        s_d.trap_rim = 1'b1;
        s_d.trap_edge = 1'b0;
      end else if (req75) begin
        s_d.vector = VEC_75;
        s_d.r75_ff = 1'b0;
      end else if (req65) begin
        s_d.vector = VEC_65;
      end else if (req55) begin
        s_d.vector = VEC_55;
      end else begin
        // Instruction is inserted by the outside party
        s_d.vector = VEC_BUS;
        s_d.ack = 1'b1;
      end
    end

    // New edges win over any clear in the same cycle
    if (trap_rise) begin
      s_d.trap_edge = 1'b1;
    end
    if (r75_edge) begin
      s_d.r75_ff = 1'b1;
    end

    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.masks <= MASK_RST;
      s_q.serial_out_line <= SOD_RST;
      s_q.ie <= 1'b0;
      s_q.r75_ff <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign S_AXI_AWREADY_O = s_q.awready;
  assign S_AXI_WREADY_O = s_q.wready;
  assign S_AXI_BVALID_O = s_q.bvalid;
  assign S_AXI_BRESP_O = s_q.bresp;
  assign S_AXI_ARREADY_O = s_q.arready;
  assign S_AXI_RVALID_O = s_q.rvalid;
  assign S_AXI_RRESP_O = s_q.rresp;
  assign S_AXI_RDATA_O = s_q.rdata;
  assign SERIAL_OUT_LINE_O = s_q.serial_out_line;
  assign INT_TAKEN_O = s_q.taken;
  assign VECTOR_O = s_q.vector;
  assign VECTOR_FETCH_ACK_O = s_q.ack;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  a_masked_blocks: assert property (
    (INT_TAKEN_O && VECTOR_O == VEC_55) |-> $past(s_q.ie && !s_q.masks[MB_55]))
    else $error("masked or disabled restart accepted");
  a_trap_forced: assert property (
    (SAMPLE_POINT_I && trap_req) |=> (INT_TAKEN_O && VECTOR_O == VEC_TRAP && !VECTOR_FETCH_ACK_O))
    else $error("non-maskable request not taken");
  a_edge_kept: assert property (
    (r75_edge && s_q.masks[MB_75]) |=> s_q.r75_ff [*1] ##0 !INT_TAKEN_O || VECTOR_O != VEC_75)
    else $error("masked edge lost");
  a_edge_clears: assert property (
    (INT_TAKEN_O && VECTOR_O == VEC_75 && !$past(r75_edge)) |-> !s_q.r75_ff)
    else $error("edge flop not cleared on service");
  a_mask_only_sim: assert property (
    !$past(sim_wr) |-> $stable(s_q.masks))
    else $error("masks changed without mask write");
  a_prio_seven: assert property (
    (SAMPLE_POINT_I && !trap_req && req75) |=> VECTOR_O == VEC_75)
    else $error("priority order broken");
  a_enable_cleared: assert property (
    INT_TAKEN_O |-> !s_q.ie)
    else $error("enable still set after service");
  a_trap_rearm: assert property (
    (INT_TAKEN_O && VECTOR_O == VEC_TRAP) |-> (!s_q.trap_edge || $past(trap_rise)))
    else $error("trap edge not consumed");
  a_rim_saved: assert property (
    (rim_rd && s_q.trap_rim && !(accept && trap_req)) |=>
      (S_AXI_RDATA_O[RM_IE_BIT] == $past(s_q.ie_saved) && !s_q.trap_rim))
    else $error("saved enable not reported");
  a_sod_update: assert property (
    (sim_wr && s_q.wdata[SM_SOE_BIT]) |=> SERIAL_OUT_LINE_O == $past(s_q.wdata[SM_SOD_BIT]))
    else $error("serial out not updated");
  a_bus_ack: assert property (
    VECTOR_FETCH_ACK_O |-> (INT_TAKEN_O && $past(SAMPLE_POINT_I) && VECTOR_O == VEC_BUS))
    else $error("acknowledge without sampled request");
endmodule : rsi_ctrl

// [tb/rsi_src_model.sv]
`timescale 1ns/1ps
module rsi_src_model
  import rsi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] want_i,
  input wire logic taken_i,
  input wire logic [7:0] vec_i,
  output logic [4:0] line_o
);
  logic [4:0] done_q;
  logic [1:0] hi_q;
  logic w75_q;
  // Sources other than the 7.5 line hold their level until their own vector is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_q <= 5'h00;
      hi_q <= 2'h0;
      w75_q <= 1'b0;
    end else begin
      done_q <= want_i & (done_q | ({5{taken_i}} & {vec_i == VEC_TRAP, 1'b0,
        vec_i == VEC_65, vec_i == VEC_55, vec_i == VEC_BUS}));
      w75_q <= want_i[3];
      hi_q <= {hi_q[0], want_i[3] & ~w75_q};
    end
  end
  // Short high pulse; an idle-high line would look like a rise after reset
  assign line_o = {want_i[4] & ~done_q[4], |hi_q, want_i[2:0] & ~done_q[2:0]};
endmodule : rsi_src_model

// [tb/test_restart_interrupt_and_serial_bit_logic.sv]
`timescale 1ns/1ps
module test_restart_interrupt_and_serial_bit_logic
  import rsi_pkg::*;
;
  typedef struct packed {
    logic [2:0] mask;
    logic en;
    logic [4:0] want;
    logic tk;
    logic [7:0] vec;
  } rsi_row_s;
  logic clk, rst, sp, ser, hold, aw, wv, ar, br, rr;
  logic awr, wrdy, bv, arr, rv, hsync, serial_out_line, tk, ack;
  logic [7:0] awa, ara, vec;
  logic [31:0] wd, q, rdata;
  logic [1:0] r, bresp, rresp;
  logic [4:0] want, lines;
  int n_mismatch = 0;
  int tests_run = 0;
  rsi_row_s rows [11] = '{
    '{3'h0, 1'b1, 5'h1F, 1'b1, VEC_TRAP},
    '{3'h0, 1'b1, 5'h0F, 1'b1, VEC_75},
    '{3'h0, 1'b1, 5'h07, 1'b1, VEC_65},
    '{3'h0, 1'b1, 5'h03, 1'b1, VEC_55},
    '{3'h0, 1'b1, 5'h01, 1'b1, VEC_BUS},
    '{3'h2, 1'b1, 5'h04, 1'b0, VEC_BUS},
    '{3'h4, 1'b1, 5'h08, 1'b0, VEC_BUS},
    '{3'h0, 1'b1, 5'h00, 1'b1, VEC_75},
    '{3'h0, 1'b1, 5'h00, 1'b0, VEC_75},
    '{3'h0, 1'b0, 5'h02, 1'b0, VEC_75},
    '{3'h7, 1'b0, 5'h10, 1'b1, VEC_TRAP}
  };

  rsi_ctrl DUT (
    .CLOCK_I(clk),
    .RST_I(rst),
    .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(aw),
    .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(br),
    .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(ar),
    .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr),
    .SAMPLE_POINT_I(sp),
    .NONMASKABLE_I(lines[4]),
    .RESTART75_I(lines[3]),
    .RESTART65_I(lines[2]),
    .RESTART55_I(lines[1]),
    .BUS_VECTORED_REQUEST_I(lines[0]),
    .SERIAL_IN_LINE_I(ser),
    .HOLD_REQUEST_I(hold),
    .HOLD_REQUEST_SYNC_O(hsync),
    .SERIAL_OUT_LINE_O(serial_out_line),
    .INT_TAKEN_O(tk),
    .VECTOR_O(vec),
    .VECTOR_FETCH_ACK_O(ack)
  );

  rsi_src_model src (
    .clk_i(clk),
    .rst_i(rst),
    .want_i(want),
    .taken_i(tk),
    .vec_i(vec),
    .line_o(lines)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Readies are judged at the falling edge, so the rising edge sees no race
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hr, hd;
    hd = 1'b0;
    @(posedge clk);
    awa <= a;
    ara <= a;
    wd <= d;
    aw <= w;
    wv <= w;
    br <= w;
    ar <= !w;
    rr <= !w;
    while (!hd) begin
      @(negedge clk);
      ha = aw && awr;
      hw = wv && wrdy;
      hr = ar && arr;
      hd = w ? (bv && br) : (rv && rr);
      q = rdata;
      r = w ? bresp : rresp;
      @(posedge clk);
      if (ha) aw <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hr) ar <= 1'b0;
      if (hd) br <= 1'b0;
      if (hd) rr <= 1'b0;
    end
  endtask : bus

  task automatic fire(input logic [4:0] w);
    @(posedge clk);
    want <= 5'h00;
    repeat (5) @(posedge clk);
    want <= w;
    repeat (10) @(posedge clk);
    sp <= 1'b1;
    #1;
    chk(tk, 0);
    @(posedge clk);
    sp <= 1'b0;
    #1;
  endtask : fire

  initial begin
    clk = 1'b0;
    forever begin
      #12.5 clk = ~clk;
    end
  end

  initial begin
    #(25 * 8000);
    n_mismatch++;
    final_report();
  end

  initial begin
    {rst, sp, ser, hold, aw, wv, ar, br, rr} = 9'h100;
    {awa, ara, wd, want} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      bus(1'b1, OFS_SETMASK, {29'h0, rows[i].mask} | 32'h08);
      bus(1'b1, rows[i].en ? OFS_ENABLE : OFS_DISABLE, 32'h0);
      fire(rows[i].want);
      chk(tk, rows[i].tk);
      chk(vec, rows[i].vec);
      chk(ack, rows[i].tk & (rows[i].vec == VEC_BUS));
      $display("row %0d done", i);
    end
    @(posedge clk);
    ser <= 1'b1;
    bus(1'b1, OFS_SETMASK, 32'hCF);
    chk(serial_out_line, 1);
    bus(1'b1, OFS_ENABLE, 32'h0);
    fire(5'h10);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[7], 1);
    chk(q[3], 1);
    chk(q[2:0], MASK_RST);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[3], 0);
    bus(1'b1, OFS_SETMASK, 32'h08);
    bus(1'b1, OFS_ENABLE, 32'h0);
    fire(5'h02);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[3], 0);
    $display("trap and mask read test done");
    bus(1'b1, OFS_SETMASK, 32'h0F);
    fire(5'h08);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[6], 1);
    bus(1'b1, OFS_SETMASK, 32'h1F);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[6], 0);
    fire(5'h08);
    bus(1'b1, OFS_ENABLE, 32'h0);
    @(posedge clk);
    want <= 5'h00;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, OFS_READMASK, 32'h0);
    chk(q[6], 0);
    chk(q[3], 0);
    chk(q[2:0], MASK_RST);
    chk(serial_out_line, SOD_RST);
    $display("mid-run reset test done");
    bus(1'b1, 8'h20, 32'hFF);
    chk(r, RESP_SLVERR);
    bus(1'b0, 8'h24, 32'h0);
    chk(r, RESP_SLVERR);
    @(posedge clk);
    hold <= 1'b1;
    #1;
    chk(hsync, 0);
    repeat (5) @(posedge clk);
    #1;
    chk(hsync, 1);
    $display("unmapped and hold test done");
    final_report();
  end
endmodule : test_restart_interrupt_and_serial_bit_logic
